// ===== dv/pmcr_regs_properties.sv
`timescale 1ns/1ps
module pmcr_chk
    import pmcr_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Configuration cycles.
    input wire pmcr_cfg_req_s cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    // Serial EEPROM loader.
    input wire pmcr_ee_load_s ee_load,
    // PHY side.
    input wire logic cable_not_active_flag,
    input wire logic cable_inactive_out,
    input wire logic cable_inactive_route_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    route_out_a: assert property (
        cable_inactive_out == $past(cable_inactive_route_en & cable_not_active_flag))
        else $error("Cable-inactive output does not follow the route bit.");

    ee_route_a: assert property (
        (ee_load.load && (ee_load.addr == PMCR_EE_BYTE))
        |=> (cable_inactive_route_en == $past(ee_load.data[PMCR_BIT_ROUTE])))
        else $error("Route bit did not take the loaded value.");

    phy_reserved_bits_a: assert property (
        (cfg_rvalid && ($past(cfg_req.addr) == PMCR_OFF_PHY))
        |-> ((cfg_rdata & ~PMCR_PHY_WMASK) == PMCR_ZERO_WORD))
        else $error("PHY reserved bits read nonzero.");

    misc_reserved_bits_a: assert property (
        (cfg_rvalid && ($past(cfg_req.addr) == PMCR_OFF_MISC))
        |-> ((cfg_rdata & ~(PMCR_MISC_WMASK | PMCR_MISC_RESET)) == PMCR_ZERO_WORD))
        else $error("Misc reserved bits read nonzero.");

    wake_cold_a: assert property (
        (cfg_rvalid && ($past(cfg_req.addr) == PMCR_OFF_MISC))
        |-> (cfg_rdata[PMCR_BIT_WAKE] == 1'b0))
        else $error("Wake-from-cold bit read as one.");

    rev_conform_a: assert property (
        (cfg_rvalid && ($past(cfg_req.addr) == PMCR_OFF_MISC))
        |-> (cfg_rdata[PMCR_BIT_REV23] == 1'b1))
        else $error("Revision conformance bit read as zero.");

endmodule : pmcr_chk

bind pmcr_regs pmcr_chk chk_i (
    .mclk(mclk),
    .resetn(resetn),
    .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid),
    .ee_load(ee_load),
    .cable_not_active_flag(cable_not_active_flag),
    .cable_inactive_out(cable_inactive_out),
    .cable_inactive_route_en(cable_inactive_route_en)
);

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench import pmcr_pkg::*;;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic cable_not_active_flag = 1'b0;
    logic cable_inactive_out;
    logic cable_inactive_route_en;
    logic cfg_rvalid;
    logic [31:0] cfg_rdata;
    logic [31:0] w;
    pmcr_cfg_req_s cfg_req = '0;
    pmcr_ee_load_s ee_load = '0;
    int miscompares = 0;
    int checks = 0;
    int seed = 85;
    // Behavioural model of the two registers and the queue of expected read words.
    logic [31:0] phy_m;
    logic [31:0] misc_m;
    logic [31:0] exp_q[$];

    pmcr_regs uut (
        .mclk(mclk),
        .resetn(resetn),
        .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid),
        .ee_load(ee_load),
        .cable_not_active_flag(cable_not_active_flag),
        .cable_inactive_out(cable_inactive_out),
        .cable_inactive_route_en(cable_inactive_route_en)
    );

    initial begin
        forever #25 mclk = ~mclk;
    end

    // About 1340 cycles of tests; the limit leaves ample margin.
    initial begin
        #300us;
        miscompares++;
        end_sim();
    end

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic model_reset();
        phy_m = 32'h0000_0008;
        misc_m = 32'h0000_0000;
    endtask : model_reset

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] be, logic [31:0] wm);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
        return (old & ~m) | (d & m);
    endfunction : merge

    task automatic cfg_write(logic [7:0] a, logic [31:0] d, logic [3:0] be);
        @(negedge mclk);
        cfg_req = '{1'b1, 1'b0, a, be, d};
        if (a == 8'hEC) begin
            phy_m = merge(phy_m, d, be, 32'h0000_009F);
        end else if (a == 8'hF0) begin
            misc_m = merge(misc_m, d, be, 32'h0000_07FF);
        end
        @(negedge mclk);
        cfg_req = '0;
    endtask : cfg_write

    task automatic cfg_read(logic [7:0] a);
        @(negedge mclk);
        cfg_req = '{1'b0, 1'b1, a, 4'h0, 32'h0000_0000};
        if (a == 8'hEC) begin
            exp_q.push_back(phy_m);
        end else if (a == 8'hF0) begin
            exp_q.push_back(misc_m | 32'h0000_0800);
        end else begin
            exp_q.push_back(32'h0000_0000);
        end
        @(negedge mclk);
        cfg_req = '0;
        chk({31'h0, cfg_rvalid}, 32'h0000_0001);
        chk(cfg_rdata, exp_q.pop_front());
    endtask : cfg_read

    task automatic ee_load_byte(logic [7:0] a, logic [7:0] d);
        @(negedge mclk);
        ee_load = '{1'b1, a, d};
        if (a == 8'h38) begin
            phy_m[7] = d[7];
        end
        @(negedge mclk);
        ee_load = '0;
        chk({31'h0, cable_inactive_route_en}, {31'h0, phy_m[7]});
    endtask : ee_load_byte

    task automatic cna_check(logic f);
        @(negedge mclk);
        cable_not_active_flag = f;
        @(negedge mclk);
        chk({31'h0, cable_inactive_out}, {31'h0, phy_m[7] & f});
    endtask : cna_check

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        model_reset();
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        cfg_read(8'hEC);
        cfg_read(8'hF0);
        $display("test reset_values done");
        repeat (60) begin
            w = $random(seed);
            cfg_write(8'hEC, w & 32'hFFFF_FFE8, w[19:16]);
            cfg_write(8'hF0, w, w[23:20]);
            cfg_write({w[31:26], 2'b00}, w & 32'hFFFF_FFE8, w[27:24]);
            cfg_read(8'hEC);
            cfg_read(8'hF0);
            cfg_read({w[29:24], 2'b00});
            cna_check(w[9]);
            ee_load_byte(8'h38, {w[15:12], 4'h8});
            ee_load_byte({w[7:2], 2'b01}, w[31:24]);
            cna_check(w[10]);
            cfg_read(8'hEC);
        end
        $display("test random_access done");
        @(negedge mclk);
        resetn = 1'b0;
        model_reset();
        @(negedge mclk);
        chk({31'h0, cfg_rvalid}, 32'h0000_0000);
        chk({31'h0, cable_inactive_out}, 32'h0000_0000);
        chk({31'h0, cable_inactive_route_en}, 32'h0000_0000);
        @(negedge mclk);
        resetn = 1'b1;
        cfg_read(8'hEC);
        cfg_read(8'hF0);
        cna_check(1'b1);
        $display("test mid_reset done");
        end_sim();
    end
endmodule : testbench

// ===== rtl/pmcr_pkg.sv
package pmcr_pkg;

    localparam logic [7:0] PMCR_OFF_PHY = 8'hEC;
    localparam logic [7:0] PMCR_OFF_MISC = 8'hF0;

    localparam int PMCR_WORD_W = 32;
    localparam int PMCR_LANES = 4;
    localparam int PMCR_LANE_W = 8;
    localparam logic [31:0] PMCR_ZERO_WORD = 32'h0000_0000;
    localparam int PMCR_BIT_WAKE = 15;
    localparam int PMCR_BIT_REV23 = 11;

    localparam logic [31:0] PMCR_PHY_RESET = 32'h0000_0008;
    localparam logic [31:0] PMCR_PHY_WMASK = 32'h0000_009F;
    localparam logic [31:0] PMCR_MISC_RESET = 32'h0000_0800;
    localparam logic [31:0] PMCR_MISC_RO_MASK = 32'h0000_F800;
    localparam logic [31:0] PMCR_MISC_WMASK = 32'h0000_07FF;

    localparam int PMCR_BIT_ROUTE = 7;
    localparam logic [7:0] PMCR_EE_BYTE = 8'h38;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pmcr_cfg_req_s;

    typedef struct packed {
        logic       load;
        logic [7:0] addr;
        logic [7:0] data;
    } pmcr_ee_load_s;

endpackage : pmcr_pkg

// ===== rtl/pmcr_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Route bit set drives cable-not-active to output.
// R2: EEPROM byte 38h bit 7 loads route bit.
// R3: PHY bit 3 resets to one, stays writable.
// R4: Software keeps PHY bits 4,2,1,0 at zero.
// R5: EEPROM byte 38h bit 3 must be one.
// R6: EEPROM byte 38h bit 1 must be zero.
// R7: PHY bits 31-8 and 6-5 read zero.
// R8: Misc bits 31-16 and 14-12 read zero.
// R9: Misc bit 15 wake-from-cold hardwired zero.
// R10: Misc bit 11 hardwired one, read-only.
// R11: Misc writable bits reset on any reset.
// R12: Read-only writes ignored; writable bits hold values.
module pmcr_regs
    import pmcr_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Configuration cycles.
    input wire pmcr_cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // Serial EEPROM loader.
    input wire pmcr_ee_load_s ee_load,
    // PHY side.
    input wire logic cable_not_active_flag,
    output logic cable_inactive_out,
    output logic cable_inactive_route_en
);

    // Decoded strobes for the current cycle.
    logic phy_wr_hit;
    logic misc_wr_hit;
    logic phy_rd_hit;
    logic misc_rd_hit;
    logic ee_route_hit;

    // Per-lane write enables and the merged register images.
    logic [PMCR_LANES-1:0] lane_we;
    logic [PMCR_WORD_W-1:0] phy_merge;
    logic [PMCR_WORD_W-1:0] misc_merge;

    // Images as software sees them on a read.
    logic [PMCR_WORD_W-1:0] phy_view;
    logic [PMCR_WORD_W-1:0] misc_view;

    // PHY link control register.
    logic [PMCR_WORD_W-1:0] phy_q;
    logic [PMCR_WORD_W-1:0] phy_d;

    // Misc bus configuration register.
    logic [PMCR_WORD_W-1:0] misc_q;
    logic [PMCR_WORD_W-1:0] misc_d;

    // Read return path.
    logic [PMCR_WORD_W-1:0] rdata_q;
    logic [PMCR_WORD_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    // Cable-not-active routing.
    logic cna_q;
    logic cna_d;
    logic route_q;
    logic route_d;

    // Write decode; writes to unmapped offsets fall through and are dropped.
    always_comb begin
        phy_wr_hit = cfg_req.wr && (cfg_req.addr == PMCR_OFF_PHY);
        misc_wr_hit = cfg_req.wr && (cfg_req.addr == PMCR_OFF_MISC);
        ee_route_hit = ee_load.load && (ee_load.addr == PMCR_EE_BYTE); // see R2
    end

    // Read decode; unmapped offsets still answer, with an all-zero word.
    always_comb begin
        phy_rd_hit = cfg_req.rd && (cfg_req.addr == PMCR_OFF_PHY);
        misc_rd_hit = cfg_req.rd && (cfg_req.addr == PMCR_OFF_MISC);
    end

    // Each byte enable gates one lane; a lane with its enable low keeps the stored byte.
    genvar lane;
    generate
        for (lane = 0; lane < PMCR_LANES; lane++) begin : g_lane
            localparam int LANE_LO = lane * PMCR_LANE_W;

            assign lane_we[lane] = cfg_req.be[lane];

            assign phy_merge[LANE_LO +: PMCR_LANE_W] = lane_we[lane] // see R12
                ? ((cfg_req.wdata[LANE_LO +: PMCR_LANE_W] & PMCR_PHY_WMASK[LANE_LO +: PMCR_LANE_W])
                    | (phy_q[LANE_LO +: PMCR_LANE_W] & ~PMCR_PHY_WMASK[LANE_LO +: PMCR_LANE_W]))
                : phy_q[LANE_LO +: PMCR_LANE_W];

            assign misc_merge[LANE_LO +: PMCR_LANE_W] = lane_we[lane] // see R12
                ? ((cfg_req.wdata[LANE_LO +: PMCR_LANE_W] & PMCR_MISC_WMASK[LANE_LO +: PMCR_LANE_W])
                    | (misc_q[LANE_LO +: PMCR_LANE_W] & ~PMCR_MISC_WMASK[LANE_LO +: PMCR_LANE_W]))
                : misc_q[LANE_LO +: PMCR_LANE_W];
        end
    endgenerate

    // PHY link control next value.
    always_comb begin
        phy_d = phy_q;
        if (phy_wr_hit) begin
            // Tuning bits stay writable; software is trusted to keep them at their defaults.
            phy_d = phy_merge; // (see R3) (see R7) (see R12)
        end
        // The loader runs after reset, so it wins over a same-cycle write.
        if (ee_route_hit) begin
            phy_d[PMCR_BIT_ROUTE] = ee_load.data[PMCR_BIT_ROUTE]; // see R2
        end
    end

    // Misc bus configuration next value.
    always_comb begin
        misc_d = misc_q;
        if (misc_wr_hit) begin
            misc_d = misc_merge; // see R12
        end
        // Hardwired bits are forced every cycle, so no write can disturb them.
        misc_d = (misc_d & PMCR_MISC_WMASK) | (PMCR_MISC_RESET & PMCR_MISC_RO_MASK); // (see R8) (see R9) (see R10)
    end

    // Read images are rebuilt from the masks rather than trusted from storage.
    always_comb begin
        phy_view = phy_q & PMCR_PHY_WMASK; // see R7
        misc_view = (misc_q & PMCR_MISC_WMASK) | (PMCR_MISC_RESET & PMCR_MISC_RO_MASK); // (see R8) (see R9) (see R10)
    end

    // Read return path next value.
    always_comb begin
        rvalid_d = cfg_req.rd;
        rdata_d = PMCR_ZERO_WORD;
        if (phy_rd_hit) begin
            rdata_d = phy_view; // see R7
        end else if (misc_rd_hit) begin
            rdata_d = misc_view; // see R8
        end
    end

    // Cable-not-active routing next value.
    always_comb begin
        cna_d = phy_q[PMCR_BIT_ROUTE] & cable_not_active_flag; // see R1
        route_d = phy_d[PMCR_BIT_ROUTE];
    end

    // Every reset source is merged into resetn upstream. (see R11)
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phy_q <= PMCR_PHY_RESET; // see R3
        end else begin
            phy_q <= phy_d;
        end
    end

    // Misc register storage. (see R11)
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            misc_q <= PMCR_MISC_RESET;
        end else begin
            misc_q <= misc_d;
        end
    end

    // Read data register; it holds one cycle after the strobe.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= PMCR_ZERO_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Read valid register.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rvalid_d;
        end
    end

    // Routed cable-not-active output; one cycle behind the flag input.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cna_q <= 1'b0;
        end else begin
            cna_q <= cna_d;
        end
    end

    // Copy of the route bit, kept so the output pin comes from its own flip-flop.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            route_q <= PMCR_PHY_RESET[PMCR_BIT_ROUTE];
        end else begin
            route_q <= route_d;
        end
    end

    // Outputs.
    assign cfg_rdata = rdata_q;
    assign cfg_rvalid = rvalid_q;
    assign cable_inactive_out = cna_q;
    assign cable_inactive_route_en = route_q;

endmodule : pmcr_regs
